// ### bench/pfcp_stage.sv
// behavioural boost stage: ramp comparator and current sense flag
`timescale 1ns/100ps
module pfcp_stage (
	input wire logic clk_i, // switching logic clock
	input wire logic reset_i, // synchronous reset, active high
	input wire logic gate_i, // gate drive from the controller
	input wire logic ramp_discharge_i, // ramp held discharged
	input wire logic [7:0] level_i, // averaged current level in steps
	input wire logic trip_i, // inductor current above the limit
	output logic ramp_cross_o, // ramp above the averaged level
	output logic cs_limit_o // current sense at the limit
);
	// ************************************************************
	// ramp and sense
	// ************************************************************
	logic [7:0] ramp_reg;
	// ramp saturates so a high level never wraps into a false crossing
	always_ff @(posedge clk_i) begin
		if (reset_i || ramp_discharge_i) begin
			ramp_reg <= 8'h00;
		end else if (ramp_reg != 8'hFF) begin
			ramp_reg <= ramp_reg + 8'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		ramp_cross_o <= !ramp_discharge_i && (ramp_reg > level_i);
	end
	// current only flows while the switch is on
	always_ff @(posedge clk_i) begin
		cs_limit_o <= trip_i && gate_i;
	end
endmodule // pfcp_stage

// ### bench/tb.sv
// self-checking testbench of the pfc switching and protection logic
`timescale 1ns/100ps
`include "pfcp_params.svh"
module tb
	import pfcp_pkg::*;
;
	// ************************************************************
	// signals
	// ************************************************************
	localparam int G = 0, SS = 1, SB = 2, BG = 3, FS = 4, FH = 5;
	logic clk_i = 0, reset_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 8'h00, level = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic supply_ok_i = 0, bo_above_upper_i = 1, bo_below_lower_i = 0;
	logic bo_low_line_i = 0, fb_open_i = 0, fb_over_i = 0, fb_good_i = 0;
	logic fb_below_rated_i = 1, fb_below_thr_i = 0, secondary_overvoltage_over_i = 0;
	logic secondary_overvoltage_release_i = 1, ten_low_i = 0, ten_high_res_i = 0;
	logic load_low_i = 0, trip = 0, lm = 0;
	logic wb_ack_o, ramp_cross_i, cs_limit_i, gate_o, ramp_discharge_o;
	logic bulk_good_o, follower_source_o, follower_hyst_o;
	logic soft_start_o, standby_o;
	int errors = 0, total_checks = 0, max_on = 0, min_off = 999;
	int on_run = 0, off_run = 0, rises = 0, i, n;

	always #50 clk_i = ~clk_i;

	pfcp_top uut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .supply_ok_i(supply_ok_i),
		.ramp_cross_i(ramp_cross_i), .cs_limit_i(cs_limit_i),
		.bo_above_upper_i(bo_above_upper_i),
		.bo_below_lower_i(bo_below_lower_i), .bo_low_line_i(bo_low_line_i),
		.fb_open_i(fb_open_i), .fb_over_i(fb_over_i),
		.fb_below_rated_i(fb_below_rated_i), .fb_good_i(fb_good_i),
		.fb_below_thr_i(fb_below_thr_i), .secondary_overvoltage_over_i(secondary_overvoltage_over_i),
		.secondary_overvoltage_release_i(secondary_overvoltage_release_i), .ten_low_i(ten_low_i),
		.ten_high_res_i(ten_high_res_i), .load_low_i(load_low_i),
		.gate_o(gate_o), .ramp_discharge_o(ramp_discharge_o),
		.bulk_good_o(bulk_good_o), .follower_source_o(follower_source_o),
		.follower_hyst_o(follower_hyst_o), .soft_start_o(soft_start_o),
		.standby_o(standby_o));

	pfcp_stage stage (.clk_i(clk_i), .reset_i(reset_i), .gate_i(gate_o),
		.ramp_discharge_i(ramp_discharge_o), .level_i(level),
		.trip_i(trip), .ramp_cross_o(ramp_cross_i),
		.cs_limit_o(cs_limit_i));

	// ************************************************************
	// helpers
	// ************************************************************
	// gate run lengths over the whole run, sampled at the edge
	always @(posedge clk_i) begin
		if (gate_o === 1'b1) begin
			if (on_run == 0) begin
				rises++;
				if (off_run < min_off) min_off = off_run;
			end
			on_run++;
			off_run = 0;
			if (on_run > max_on) max_on = on_run;
		end else begin
			on_run = 0;
			off_run++;
		end
	end

	task summarize;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task check(input logic got, input logic exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask

	function logic sig(input int w);
		case (w)
			G: return gate_o;
			SS: return soft_start_o;
			SB: return standby_o;
			BG: return bulk_good_o;
			FS: return follower_source_o;
			default: return follower_hyst_o;
		endcase
	endfunction

	// secondary fault parks in latch or waits for release in auto mode
	function pfcp_state_t secondary_overvoltage_state(input logic latch);
		return latch ? ST_LATCH : ST_WAIT;
	endfunction

	task idle(input int c);
		repeat (c) @(posedge clk_i);
	endtask

	task wait_for(input int w, input logic v, input int lim, input string m);
		int k;
		k = 0;
		while (sig(w) !== v && k < lim) begin
			@(posedge clk_i);
			k++;
		end
		check(sig(w), v, m);
	endtask

	task stays(input int w, input logic v, input int c, input string m);
		int bad;
		bad = 0;
		repeat (c) begin
			@(posedge clk_i);
			if (sig(w) !== v) bad++;
		end
		check(bad == 0, 1'b1, m);
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		rd = wb_dat_o;
		check(wb_ack_o, 1'b1, "no bus acknowledge");
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask

	task to_run(input string m);
		wait_for(SS, 1, 800, m);
		fb_good_i <= 1;
		wait_for(BG, 1, 60, m);
		wait_for(G, 1, 400, m);
	endtask

	// the scenarios need under 10,000 cycles; this allows twice that
	initial begin
		#2000000;
		errors++;
		summarize;
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		rd = $urandom(32'h0875);
		lm = $urandom & 1;
		ten_high_res_i <= lm;
		idle(8);
		check(gate_o, 1'b0, "gate not low in reset");
		check(ramp_discharge_o, 1'b1, "ramp not held in reset");
		reset_i <= 0;
		wb(0, `PFCP_CTRL_OFS, 32'h0);
		check(rd[1:0] === `PFCP_CTRL_RST, 1'b1, "control reset value");
		wb(1, 8'h10, 32'hFFFFFFFF);
		wb(0, 8'h10, 32'h0);
		check(rd === 32'h0, 1'b1, "unmapped read not zero");
		load_low_i <= 1;
		bo_low_line_i <= 1;
		supply_ok_i <= 1;
		wait_for(SS, 1, 800, "no soft-start");
		stays(FS, 0, 30, "follower in soft-start");
		check(bulk_good_o, 1'b0, "bulk good early");
		wb(0, `PFCP_STAT_OFS, 32'h0);
		check(rd[4], lm, "recovery mode");
		fb_good_i <= 1;
		wait_for(BG, 1, 60, "bulk good missing");
		wait_for(FS, 1, 30, "follower off");
		check(follower_hyst_o, 1'b1, "hysteresis switch off");
		wb(1, `PFCP_CTRL_OFS, 32'h3);
		wait_for(FS, 0, 20, "follower not disabled");
		wb(1, `PFCP_CTRL_OFS, 32'h1);
		wait_for(FS, 1, 20, "follower not back");
		load_low_i <= 0;
		wait_for(FS, 0, 20, "follower with load high");
		check(follower_hyst_o, 1'b0, "hysteresis switch on");
		bo_low_line_i <= 0;
		rises = 0;
		idle(400);
		for (i = 0; i < 8; i++) begin
			// levels up to 0x6D cross before the duty cap: every cycle pulses
			level <= 8'h0A + 8'($urandom % 100);
			idle(300);
		end
		check(rises >= 15, 1'b1, "gate not switching");
		wb(0, `PFCP_STAT_OFS, 32'h0);
		check(rd[2:0] === ST_RUN, 1'b1, "not running");
		wait_for(G, 1, 200, "gate not on");
		trip <= 1;
		wait_for(G, 0, 10, "current limit late");
		n = 0;
		while (ramp_discharge_o !== 1'b1 && n < 200) begin
			check(gate_o, 1'b0, "gate back in tripped cycle");
			@(posedge clk_i);
			n++;
		end
		trip <= 0;
		wait_for(G, 1, 300, "latches not cleared");
		fb_below_rated_i <= 0;
		fb_over_i <= 1;
		idle(60);
		fb_over_i <= 0;
		idle(10);
		wb(0, `PFCP_STAT_OFS, 32'h0);
		check(rd[8], 1'b0, "short over-voltage acted");
		fb_over_i <= 1;
		idle(150);
		stays(G, 0, 100, "gate during over-voltage");
		fb_over_i <= 0;
		stays(G, 0, 100, "gate above rated");
		fb_below_rated_i <= 1;
		wait_for(G, 1, 300, "no resume below rated");
		bo_below_lower_i <= 1;
		bo_above_upper_i <= 0;
		idle(100);
		bo_below_lower_i <= 0;
		wb(0, `PFCP_STAT_OFS, 32'h0);
		check(rd[2:0] === ST_RUN, 1'b1, "short brownout acted");
		bo_below_lower_i <= 1;
		fb_good_i <= 0;
		idle(220);
		stays(G, 0, 100, "gate in brownout");
		bo_below_lower_i <= 0;
		stays(G, 0, 100, "restart inside hysteresis");
		bo_above_upper_i <= 1;
		to_run("no brownout restart");
		fb_open_i <= 1;
		fb_good_i <= 0;
		idle(20);
		stays(G, 0, 100, "gate in open loop");
		fb_open_i <= 0;
		to_run("no open loop restart");
		ten_low_i <= 1;
		wait_for(SB, 1, 150, "no standby");
		stays(G, 0, 50, "gate in standby");
		ten_low_i <= 0;
		fb_good_i <= 0;
		to_run("no standby recovery");
		fb_below_thr_i <= 1;
		wait_for(BG, 0, 10, "bulk good not dropped");
		fb_below_thr_i <= 0;
		secondary_overvoltage_over_i <= 1;
		secondary_overvoltage_release_i <= 0;
		fb_below_rated_i <= 0;
		fb_over_i <= 1;
		fb_good_i <= 0;
		idle(130);
		stays(G, 0, 50, "gate in secondary fault");
		wb(0, `PFCP_STAT_OFS, 32'h0);
		check(rd[2:0] === secondary_overvoltage_state(lm), 1'b1, "fault state");
		check(rd[9:8] === 2'b11, 1'b1, "both holds not set");
		secondary_overvoltage_over_i <= 0;
		fb_over_i <= 0;
		idle(20);
		secondary_overvoltage_release_i <= 1;
		stays(G, 0, 100, "gate before both released");
		fb_below_rated_i <= 1;
		if (lm) stays(G, 0, 300, "latched fault restarted");
		else to_run("no auto restart");
		supply_ok_i <= 0;
		wait_for(G, 0, 10, "gate on in lockout");
		stays(G, 0, 50, "gate on in lockout");
		// second power-up with the other recovery mode strapped
		ten_high_res_i <= !lm;
		fb_good_i <= 0;
		supply_ok_i <= 1;
		wait_for(SS, 1, 800, "no second start");
		wb(0, `PFCP_STAT_OFS, 32'h0);
		check(rd[4], !lm, "mode not sampled again");
		secondary_overvoltage_over_i <= 1;
		secondary_overvoltage_release_i <= 0;
		idle(130);
		wb(0, `PFCP_STAT_OFS, 32'h0);
		check(rd[2:0] === secondary_overvoltage_state(!lm), 1'b1, "second fault");
		check(max_on <= `PFCP_MAXON_CYC, 1'b1, "on-time too long");
		check(min_off >= `PFCP_TOFF_CYC, 1'b1, "off-time too short");
		summarize;
	end
endmodule // tb

// ### common/pfcp_params.svh
// timing counts, register offsets and reset values of the pfc logic
`ifndef PFCP_PARAMS_SVH
`define PFCP_PARAMS_SVH

// ************************************************************
// clock and switching cycle
// ************************************************************
`define PFCP_CLK_MHZ 10
`define PFCP_FSW_KHZ 65
`define PFCP_PERIOD_CYC (`PFCP_CLK_MHZ * 1000 / `PFCP_FSW_KHZ)
`define PFCP_DMAX_PCT 95
`define PFCP_MAXON_CYC (`PFCP_PERIOD_CYC * `PFCP_DMAX_PCT / 100)
`define PFCP_TOFF_NS 600
`define PFCP_TOFF_CYC ((`PFCP_TOFF_NS * `PFCP_CLK_MHZ + 999) / 1000)

// ************************************************************
// least persistence times before a flag acts, and the mode detect window
// ************************************************************
`define PFCP_DGL_NS 200
`define PFCP_DGL_CYC ((`PFCP_DGL_NS * `PFCP_CLK_MHZ + 999) / 1000)
`define PFCP_BO_US 20
`define PFCP_BO_CYC (`PFCP_BO_US * `PFCP_CLK_MHZ)
`define PFCP_OLP_US 1
`define PFCP_OLP_CYC (`PFCP_OLP_US * `PFCP_CLK_MHZ)
`define PFCP_OVP_US 12
`define PFCP_OVP_CYC (`PFCP_OVP_US * `PFCP_CLK_MHZ)
`define PFCP_EN_US 9
`define PFCP_EN_CYC (`PFCP_EN_US * `PFCP_CLK_MHZ)
`define PFCP_MODE_US 18
`define PFCP_MODE_CYC (`PFCP_MODE_US * `PFCP_CLK_MHZ)

// ************************************************************
// register map
// ************************************************************
`define PFCP_CTRL_OFS 8'h00
`define PFCP_STAT_OFS 8'h04
`define PFCP_CTRL_RUN_BIT 0
`define PFCP_CTRL_NOBF_BIT 1
`define PFCP_CTRL_RST 2'h1

`endif

// ### common/pfcp_pkg.sv
// types shared by the pfc logic
package pfcp_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_DETECT,
		ST_WAIT,
		ST_STANDBY,
		ST_SOFT,
		ST_RUN,
		ST_LATCH
	} pfcp_state_t;
	typedef logic [7:0] pfcp_cnt_t;
endpackage

// ### core/pfcp_filter.sv
// two-stage synchroniser followed by a persistence qualifier
`timescale 1ns/100ps
module pfcp_filter
	import pfcp_pkg::*;
#(
	parameter pfcp_cnt_t HOLD = 8'h00
) (
	input wire logic clk_i, // switching logic clock
	input wire logic reset_i, // synchronous reset, active high
	input wire logic raw_i, // asynchronous comparator flag
	output logic qual_o // flag after sync and persistence
);
	logic s1_reg;
	logic s2_reg;
	pfcp_cnt_t cnt_reg;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
		end else begin
			s1_reg <= raw_i;
			s2_reg <= s1_reg;
		end
	end

	// any low sample restarts the count, so high runs under HOLD+1 samples never reach qual_o
	always_ff @(posedge clk_i) begin
		if (reset_i || !s2_reg) begin
			cnt_reg <= 8'h00;
			qual_o <= 1'b0;
		end else if (cnt_reg >= HOLD) begin
			qual_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	AST_FILT_DROP: assert property (@(posedge clk_i) disable iff (reset_i)
		!s2_reg |=> !qual_o) // [R24]
		else $error("qualified flag stayed high after input fell");
endmodule // pfcp_filter

// ### core/pfcp_top.sv
// switching cycle, pwm latches and protection sequencing of the pfc
// Functional notes
// [R1] each cycle starts 600 ns gate off, ramp discharged
// [R2] ramp released; crossing turns gate on
// [R3] on-time capped to 95 % at 65 kHz
// [R4] current limit ends gate for the cycle
// [R5] minimum off resets both latches first
// [R6] brownout: run above 1.25 V, fault below 1.0 V
// [R7] current limit at -0.2 V, 200 ns deglitch
// [R8] feedback below 0.5 V flags open loop
// [R9] feedback above 2.7 V stops gate until rated
// [R10] secondary input above 2.5 V stops gate
// [R11] enable-pin resistance sampled once sets recovery
// [R12] both over-voltages: off until both released
// [R13] soft-start raises bulk good at 95 %
// [R14] bulk good falls at pin-set threshold
// [R15] enable pin low forces standby, soft recovery
// [R16] follower on at low line, light load
// [R17] follower switches hysteresis resistor on load pin
// [R18] follower off in soft-start or load high
// [R19] gate active high, low under supply lockout
// [R20] auto mode restarts below 2.3 V
// [R21] open loop powers down, restarts above 0.5 V
// [R22] brownout needs 20 us, restarts via soft-start
// [R23] primary over-voltage needs 12 us persistence
// [R24] all comparator flags synchronised on clock
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`include "pfcp_params.svh"
module pfcp_top
	import pfcp_pkg::*;
(
	input wire logic clk_i, // 10 MHz clock
	input wire logic reset_i, // synchronous reset, active high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic supply_ok_i, // supply above lockout threshold
	input wire logic ramp_cross_i, // ramp above averaged current node
	input wire logic cs_limit_i, // current sense at or below -0.2 V
	input wire logic bo_above_upper_i, // brownout input above 1.25 V
	input wire logic bo_below_lower_i, // brownout input below 1.0 V
	input wire logic bo_low_line_i, // brownout input below 2.3 V
	input wire logic fb_open_i, // bulk feedback below 0.5 V
	input wire logic fb_over_i, // bulk feedback above 2.7 V
	input wire logic fb_below_rated_i, // bulk feedback below 2.5 V
	input wire logic fb_good_i, // bulk feedback above 95 %
	input wire logic fb_below_thr_i, // feedback below pin-set threshold
	input wire logic secondary_overvoltage_over_i, // secondary input above 2.5 V
	input wire logic secondary_overvoltage_release_i, // secondary input below 2.3 V
	input wire logic ten_low_i, // threshold enable below 0.5 V
	input wire logic ten_high_res_i, // enable pin resistance high
	input wire logic load_low_i, // load level below 0.5 V
	output logic gate_o, // gate drive, active high
	output logic ramp_discharge_o, // hold ramp discharged
	output logic bulk_good_o, // bulk good output
	output logic follower_source_o, // 20 uA out of feedback pin
	output logic follower_hyst_o, // parallel resistor on load pin
	output logic soft_start_o, // soft-start in progress
	output logic standby_o // standby mode
);
	// ************************************************************
	// comparator flags
	// ************************************************************
	logic up_q, cross_q, cl_q, bo_up_q, bo_low_q, line_q, olp_q;
	logic primary_overvoltage_q, rated_q, good_q, thr_q, secondary_overvoltage_q, rel_q, ten_q;
	logic hres_q, load_q;

	pfcp_filter #(.HOLD(8'h00)) u_up (.clk_i(clk_i), .reset_i(reset_i),
		.raw_i(supply_ok_i), .qual_o(up_q)); // [R24]
	pfcp_filter #(.HOLD(8'h00)) u_cr (.clk_i(clk_i), .reset_i(reset_i),
		.raw_i(ramp_cross_i), .qual_o(cross_q));
	pfcp_filter #(.HOLD(8'(`PFCP_DGL_CYC))) u_cl (.clk_i(clk_i),
		.reset_i(reset_i), .raw_i(cs_limit_i), .qual_o(cl_q)); // [R7]
	pfcp_filter #(.HOLD(8'h00)) u_bu (.clk_i(clk_i), .reset_i(reset_i),
		.raw_i(bo_above_upper_i), .qual_o(bo_up_q));
	pfcp_filter #(.HOLD(8'(`PFCP_BO_CYC))) u_bl (.clk_i(clk_i),
		.reset_i(reset_i), .raw_i(bo_below_lower_i),
		.qual_o(bo_low_q)); // [R22]
	pfcp_filter #(.HOLD(8'h00)) u_ln (.clk_i(clk_i), .reset_i(reset_i),
		.raw_i(bo_low_line_i), .qual_o(line_q));
	pfcp_filter #(.HOLD(8'(`PFCP_OLP_CYC))) u_ol (.clk_i(clk_i),
		.reset_i(reset_i), .raw_i(fb_open_i), .qual_o(olp_q)); // [R8]
	pfcp_filter #(.HOLD(8'(`PFCP_OVP_CYC))) u_o1 (.clk_i(clk_i),
		.reset_i(reset_i), .raw_i(fb_over_i), .qual_o(primary_overvoltage_q)); // [R23]
	pfcp_filter #(.HOLD(8'h00)) u_rt (.clk_i(clk_i), .reset_i(reset_i),
		.raw_i(fb_below_rated_i), .qual_o(rated_q));
	pfcp_filter #(.HOLD(8'h00)) u_gd (.clk_i(clk_i), .reset_i(reset_i),
		.raw_i(fb_good_i), .qual_o(good_q));
	pfcp_filter #(.HOLD(8'h00)) u_th (.clk_i(clk_i), .reset_i(reset_i),
		.raw_i(fb_below_thr_i), .qual_o(thr_q));
	pfcp_filter #(.HOLD(8'(`PFCP_OVP_CYC))) u_o2 (.clk_i(clk_i),
		.reset_i(reset_i), .raw_i(secondary_overvoltage_over_i), .qual_o(secondary_overvoltage_q));
	pfcp_filter #(.HOLD(8'h00)) u_rl (.clk_i(clk_i), .reset_i(reset_i),
		.raw_i(secondary_overvoltage_release_i), .qual_o(rel_q));
	pfcp_filter #(.HOLD(8'(`PFCP_EN_CYC))) u_en (.clk_i(clk_i),
		.reset_i(reset_i), .raw_i(ten_low_i), .qual_o(ten_q)); // [R15]
	pfcp_filter #(.HOLD(8'h00)) u_hr (.clk_i(clk_i), .reset_i(reset_i),
		.raw_i(ten_high_res_i), .qual_o(hres_q));
	pfcp_filter #(.HOLD(8'h00)) u_ld (.clk_i(clk_i), .reset_i(reset_i),
		.raw_i(load_low_i), .qual_o(load_q));

	// ************************************************************
	// registers and state
	// ************************************************************
	pfcp_state_t st_reg;
	pfcp_cnt_t pwm_cnt_reg;
	pfcp_cnt_t det_cnt_reg;
	logic [1:0] ctrl_reg;
	logic latch_mode_reg;
	logic primary_overvoltage_hold_reg;
	logic secondary_overvoltage_hold_reg;
	logic on_latch_reg;
	logic cl_latch_reg;
	logic toff;
	logic run_ok;
	logic stby_req;
	logic bf_on;
	logic wb_req;
	logic [31:0] rd_next;

	assign toff = pwm_cnt_reg < 8'(`PFCP_TOFF_CYC);
	assign stby_req = ten_q || !ctrl_reg[`PFCP_CTRL_RUN_BIT];
	// either over-voltage hold keeps the gate off on its own
	assign run_ok = (st_reg == ST_SOFT || st_reg == ST_RUN) &&
		!primary_overvoltage_hold_reg && !secondary_overvoltage_hold_reg && !primary_overvoltage_q &&
		!secondary_overvoltage_q; // [R12]
	assign bf_on = st_reg == ST_RUN && line_q && load_q &&
		!ctrl_reg[`PFCP_CTRL_NOBF_BIT]; // [R16] [R18]

	// ************************************************************
	// protection state machine
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (reset_i || !up_q) begin
			st_reg <= ST_OFF; // [R19]
			det_cnt_reg <= 8'h00;
		end else begin
			case (st_reg)
				ST_OFF: begin
					st_reg <= ST_DETECT;
					det_cnt_reg <= 8'h00;
				end
				ST_DETECT: begin
					if (det_cnt_reg >= 8'(`PFCP_MODE_CYC)) begin
						st_reg <= ST_WAIT;
					end else begin
						det_cnt_reg <= det_cnt_reg + 8'h01;
					end
				end
				ST_WAIT: begin
					if (stby_req) begin
						st_reg <= ST_STANDBY;
					end else if (bo_up_q && !olp_q && !secondary_overvoltage_hold_reg &&
						!secondary_overvoltage_q) begin
						st_reg <= ST_SOFT; // [R6] [R20] [R21] [R22]
					end
				end
				ST_STANDBY: begin
					if (!stby_req) begin
						st_reg <= ST_WAIT; // [R15]
					end
				end
				ST_SOFT, ST_RUN: begin
					if (stby_req) begin
						st_reg <= ST_STANDBY; // [R15]
					end else if (secondary_overvoltage_q && latch_mode_reg) begin
						st_reg <= ST_LATCH; // [R11]
					end else if (bo_low_q || olp_q || secondary_overvoltage_q) begin
						st_reg <= ST_WAIT; // [R6] [R21] [R20]
					end else if (st_reg == ST_SOFT && good_q) begin
						st_reg <= ST_RUN;
					end
				end
				ST_LATCH: begin
					st_reg <= ST_LATCH;
				end
				default: begin
					st_reg <= ST_OFF;
				end
			endcase
		end
	end

	// recovery mode is caught once, at the end of the detect window
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			latch_mode_reg <= 1'b0;
		end else if (st_reg == ST_DETECT &&
			det_cnt_reg >= 8'(`PFCP_MODE_CYC)) begin
			latch_mode_reg <= hres_q; // [R11]
		end
	end

	// set wins over release so a fresh trip is never lost
	always_ff @(posedge clk_i) begin
		if (reset_i || !up_q) begin
			primary_overvoltage_hold_reg <= 1'b0;
			secondary_overvoltage_hold_reg <= 1'b0;
		end else begin
			if (primary_overvoltage_q) begin
				primary_overvoltage_hold_reg <= 1'b1; // [R9]
			end else if (rated_q) begin
				primary_overvoltage_hold_reg <= 1'b0; // [R9] [R23]
			end
			if (secondary_overvoltage_q) begin
				secondary_overvoltage_hold_reg <= 1'b1; // [R10]
			end else if (rel_q) begin
				secondary_overvoltage_hold_reg <= 1'b0; // [R20]
			end
		end
	end

	// ************************************************************
	// switching cycle and pwm latches
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (reset_i || pwm_cnt_reg >= 8'(`PFCP_PERIOD_CYC - 1)) begin
			pwm_cnt_reg <= 8'h00;
		end else begin
			pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || toff) begin
			on_latch_reg <= 1'b0; // [R5]
			cl_latch_reg <= 1'b0; // [R5]
		end else begin
			if (cross_q) begin
				on_latch_reg <= 1'b1; // [R2]
			end
			if (cl_q) begin
				cl_latch_reg <= 1'b1; // [R4]
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			gate_o <= 1'b0;
			ramp_discharge_o <= 1'b1;
		end else begin
			gate_o <= run_ok && up_q && !toff && on_latch_reg &&
				!cl_latch_reg && !cl_q &&
				pwm_cnt_reg < 8'(`PFCP_MAXON_CYC); // [R1] [R3] [R4] [R19]
			ramp_discharge_o <= toff || !run_ok; // [R1] [R2]
		end
	end

	// ************************************************************
	// status outputs
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (reset_i || !up_q) begin
			bulk_good_o <= 1'b0;
		end else if (st_reg == ST_SOFT && good_q) begin
			bulk_good_o <= 1'b1; // [R13]
		end else if (thr_q || st_reg == ST_STANDBY ||
			st_reg == ST_LATCH || st_reg == ST_WAIT) begin
			bulk_good_o <= 1'b0; // [R14]
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			follower_source_o <= 1'b0;
			follower_hyst_o <= 1'b0;
			soft_start_o <= 1'b0;
			standby_o <= 1'b0;
		end else begin
			follower_source_o <= bf_on; // [R16]
			follower_hyst_o <= bf_on; // [R17]
			soft_start_o <= st_reg == ST_SOFT;
			standby_o <= st_reg == ST_STANDBY; // [R15]
		end
	end

	// ************************************************************
	// wishbone slave
	// ************************************************************
	assign wb_req = wb_cyc_i && wb_stb_i;

	always_comb begin
		rd_next = 32'h00000000;
		case (wb_adr_i)
			`PFCP_CTRL_OFS: rd_next[1:0] = ctrl_reg;
			`PFCP_STAT_OFS: rd_next[10:0] = {cl_latch_reg,
				secondary_overvoltage_hold_reg, primary_overvoltage_hold_reg, follower_source_o,
				bulk_good_o, gate_o, latch_mode_reg, 1'b0, st_reg};
			default: rd_next = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req && !wb_ack_o;
			wb_dat_o <= rd_next;
		end
	end

	// write lands on the edge where the master sees ack
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_reg <= `PFCP_CTRL_RST;
		end else if (wb_req && wb_we_i && wb_ack_o && wb_sel_i[0] &&
			wb_adr_i == `PFCP_CTRL_OFS) begin
			ctrl_reg <= wb_dat_i[1:0];
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	AST_TOFF_GATE: assert property (toff |=> !gate_o) // [R1]
		else $error("gate high inside minimum off interval");
	AST_TOFF_RAMP: assert property (toff |=> ramp_discharge_o) // [R1]
		else $error("ramp released inside minimum off interval");
	AST_MAX_ON: assert property (gate_o |->
		$past(pwm_cnt_reg) < 8'(`PFCP_MAXON_CYC)) // [R3]
		else $error("gate on beyond maximum duty");
	AST_CL_CYCLE: assert property (cl_latch_reg && !toff |=>
		!gate_o) // [R4]
		else $error("gate on after current limit in same cycle");
	AST_LATCH_RST: assert property (toff && (cross_q || cl_q) |=>
		!on_latch_reg && !cl_latch_reg) // [R5]
		else $error("minimum off did not reset pwm latches");
	AST_UVLO: assert property (!up_q |=> !gate_o ##1 !gate_o) // [R19]
		else $error("gate on under supply lockout");
	AST_PRIMARY_OVERVOLTAGE: assert property (primary_overvoltage_q |=> !gate_o) // [R9]
		else $error("gate on during primary over-voltage");
	AST_SECONDARY_OVERVOLTAGE: assert property (secondary_overvoltage_q |=> !gate_o) // [R10]
		else $error("gate on during secondary over-voltage");
	AST_BF_SOFT: assert property (st_reg == ST_SOFT |=>
		!follower_source_o) // [R18]
		else $error("follower active in soft-start");
	AST_BG_RISE: assert property ($rose(bulk_good_o) |->
		$past(st_reg) == ST_SOFT && $past(good_q)) // [R13]
		else $error("bulk good rose outside soft-start");

	COV_GATE_ON: cover property ($rose(gate_o));
	COV_CL_TRIP: cover property (cl_latch_reg && !toff);
	COV_LATCHED: cover property (st_reg == ST_LATCH);
	COV_FOLLOW: cover property (follower_source_o);
endmodule // pfcp_top
